// >>> octal_rate_pkg.sv
package octal_rate_pkg;
    // Command codes of the addressed register access
    localparam logic [7:0]  CMD_REG_WRITE     = 8'h71;
    localparam logic [7:0]  CMD_REG_READ      = 8'h65;
    // Register addresses of configuration register 5
    localparam logic [23:0] ADDR_CFG5_VOL     = 24'h800006;
    localparam logic [23:0] ADDR_CFG5_NV      = 24'h000006;
    // Field positions in configuration register 5
    localparam int          BIT_OCTAL_EN      = 0;
    localparam int          BIT_RATE          = 1;
    // Parameter-table addresses and contents
    localparam logic [8:0]  PT_ADDR_SINGLE_VOL = 9'h1BB;
    localparam logic [8:0]  PT_ADDR_SINGLE_NV  = 9'h1BF;
    localparam logic [8:0]  PT_ADDR_DDR_VOL   = 9'h1C3;
    localparam logic [8:0]  PT_ADDR_DDR_NV    = 9'h1C7;
    localparam logic [7:0]  PT_DATA_SINGLE    = 8'hD1;
    localparam logic [7:0]  PT_DATA_DDR       = 8'h91;
    localparam logic [7:0]  PT_DATA_OTHER     = 8'h00;
    // Values after reset
    localparam logic [7:0]  CFG5_NV_RESET     = 8'h02;
    localparam logic [7:0]  RD_DATA_RESET     = 8'h00;
endpackage : octal_rate_pkg

// >>> octal_rate_mode_descriptors.sv
`timescale 1ns/1ps
module octal_rate_mode_descriptors (
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_cmd_valid,
    input  wire logic [7:0]  i_cmd_code,
    input  wire logic [23:0] i_cmd_addr,
    input  wire logic [7:0]  i_cmd_wdata,
    input  wire logic        i_txn_start,
    input  wire logic        i_pt_rd,
    input  wire logic [8:0]  i_pt_addr,
    output logic      [7:0]  o_rd_data,
    output logic             o_rd_valid,
    output logic      [7:0]  o_pt_data,
    output logic             o_pt_valid,
    output logic             o_octal_en,
    output logic             o_double_rate,
    output logic             o_single_transfer_rate
);
    // Held copies of configuration register 5
    logic [7:0] cfg5_vol_r;
    logic [7:0] cfg5_nv_r;

    // Mode as sampled at the last transaction start
    logic       rate_r;
    logic       octal_r;

    // Command decode
    logic       hit_vol;
    logic       hit_nv;
    logic       cmd_wr;
    logic       cmd_rd;
    logic       wr_vol;
    logic       wr_nv;

    // Next values of the registered answers
    logic [7:0] rd_data_nxt;
    logic [7:0] pt_data_nxt;
    logic       octal_en_nxt;
    logic       double_rate_nxt;
    logic       single_rate_nxt;

    // Command strobe carrying a given code
    function automatic logic cmd_is(
        input logic       valid,
        input logic [7:0] code,
        input logic [7:0] want
    );
        cmd_is = valid && (code == want);
    endfunction : cmd_is

    // Register address matching one copy
    function automatic logic addr_is(
        input logic [23:0] addr,
        input logic [23:0] want
    );
        addr_is = (addr == want);
    endfunction : addr_is

    // Table byte lookup, unlisted bytes read as zero
    function automatic logic [7:0] pt_lookup(input logic [8:0] a);
        case (a)
            octal_rate_pkg::PT_ADDR_SINGLE_VOL: pt_lookup = octal_rate_pkg::PT_DATA_SINGLE;
            octal_rate_pkg::PT_ADDR_SINGLE_NV:  pt_lookup = octal_rate_pkg::PT_DATA_SINGLE;
            octal_rate_pkg::PT_ADDR_DDR_VOL:    pt_lookup = octal_rate_pkg::PT_DATA_DDR;
            octal_rate_pkg::PT_ADDR_DDR_NV:     pt_lookup = octal_rate_pkg::PT_DATA_DDR;
            default:                            pt_lookup = octal_rate_pkg::PT_DATA_OTHER;
        endcase
    endfunction : pt_lookup

    // Register read selection, unmapped addresses read as zero
    function automatic logic [7:0] reg_select(
        input logic       sel_vol,
        input logic       sel_nv,
        input logic [7:0] vol,
        input logic [7:0] nv
    );
        if (sel_vol) begin
            reg_select = vol;
        end else if (sel_nv) begin
            reg_select = nv;
        end else begin
            reg_select = octal_rate_pkg::RD_DATA_RESET;
        end
    endfunction : reg_select

    // Address decode of the two register copies
    assign hit_vol = addr_is(i_cmd_addr, octal_rate_pkg::ADDR_CFG5_VOL);
    assign hit_nv  = addr_is(i_cmd_addr, octal_rate_pkg::ADDR_CFG5_NV);

    // Command code decode, foreign codes do nothing
    assign cmd_wr = cmd_is(i_cmd_valid, i_cmd_code, octal_rate_pkg::CMD_REG_WRITE);
    assign cmd_rd = cmd_is(i_cmd_valid, i_cmd_code, octal_rate_pkg::CMD_REG_READ);

    // Write strobes of each copy
    assign wr_vol = cmd_wr && hit_vol;
    assign wr_nv  = cmd_wr && hit_nv;

    // Next read and table answers
    assign rd_data_nxt = reg_select(hit_vol, hit_nv, cfg5_vol_r, cfg5_nv_r);
    assign pt_data_nxt = pt_lookup(i_pt_addr);

    // Next mode outputs, rate bit only counts in octal mode
    assign octal_en_nxt    = octal_r;
    assign double_rate_nxt = octal_r && rate_r;
    assign single_rate_nxt = octal_r && !rate_r;

    // Non-volatile copy, starts from its own default
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfg5_nv_r <= octal_rate_pkg::CFG5_NV_RESET;
        end else if (wr_nv) begin
            cfg5_nv_r <= i_cmd_wdata;
        end
    end

    // Volatile copy, starts from the same default
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfg5_vol_r <= octal_rate_pkg::CFG5_NV_RESET;
        end else if (wr_vol) begin
            cfg5_vol_r <= i_cmd_wdata;
        end
    end

    // Read answer strobe, one cycle per read command
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= cmd_rd;
        end
    end

    // Read data, held until the next read
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rd_data <= octal_rate_pkg::RD_DATA_RESET;
        end else if (cmd_rd) begin
            o_rd_data <= rd_data_nxt;
        end
    end

    // Table answer strobe, one cycle after the request
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pt_valid <= 1'b0;
        end else begin
            o_pt_valid <= i_pt_rd;
        end
    end

    // Table data, held until the next table read
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pt_data <= octal_rate_pkg::PT_DATA_OTHER;
        end else if (i_pt_rd) begin
            o_pt_data <= pt_data_nxt;
        end
    end

    // Rate bit sampled at transaction start, so a mid-transfer write waits
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rate_r <= octal_rate_pkg::CFG5_NV_RESET[octal_rate_pkg::BIT_RATE];
        end else if (i_txn_start) begin
            rate_r <= cfg5_vol_r[octal_rate_pkg::BIT_RATE];
        end
    end

    // Octal enable sampled at transaction start
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            octal_r <= octal_rate_pkg::CFG5_NV_RESET[octal_rate_pkg::BIT_OCTAL_EN];
        end else if (i_txn_start) begin
            octal_r <= cfg5_vol_r[octal_rate_pkg::BIT_OCTAL_EN];
        end
    end

    // Octal mode output
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_octal_en <= 1'b0;
        end else begin
            o_octal_en <= octal_en_nxt;
        end
    end

    // Double-rate output
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_double_rate <= 1'b0;
        end else begin
            o_double_rate <= double_rate_nxt;
        end
    end

    // Single-rate output
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_single_transfer_rate <= 1'b0;
        end else begin
            o_single_transfer_rate <= single_rate_nxt;
        end
    end
endmodule : octal_rate_mode_descriptors

// >>> rate_mode_props.sv
`timescale 1ns/1ps
module rate_mode_props (
    input wire logic        i_clk, i_arst_n, i_cmd_valid, i_pt_rd, i_txn_start, o_pt_valid,
    input wire logic        o_octal_en, o_double_rate, o_single_transfer_rate,
    input wire logic [7:0]  i_cmd_code, i_cmd_wdata, o_rd_data, o_pt_data,
    input wire logic [8:0]  i_pt_addr,
    input wire logic [23:0] i_cmd_addr
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_cmd(c, a); i_cmd_valid && i_cmd_code == c && i_cmd_addr == a; endsequence
    property p_pt(a, d); i_pt_rd && i_pt_addr == a |=> o_pt_valid && o_pt_data == d; endproperty
    property p_rw(a);
        s_cmd(8'h71, a) ##2 s_cmd(8'h65, a) |=> o_rd_data == $past(i_cmd_wdata, 3);
    endproperty
    AST_PT_1BB: assert property (p_pt(9'h1BB, 8'hD1)) else $error("table 1BB");
    AST_PT_1BF: assert property (p_pt(9'h1BF, 8'hD1)) else $error("table 1BF");
    AST_PT_1C3: assert property (p_pt(9'h1C3, 8'h91)) else $error("table 1C3");
    AST_PT_1C7: assert property (p_pt(9'h1C7, 8'h91)) else $error("table 1C7");
    AST_VOL_RW: assert property (p_rw(24'h800006)) else $error("volatile copy");
    AST_NV_RW: assert property (p_rw(24'h000006)) else $error("nv copy");
    AST_RATE: assert property (o_double_rate |-> o_octal_en && !o_single_transfer_rate)
        else $error("rate flags clash");
    AST_HOLD: assert property (!i_txn_start && !$past(i_txn_start) |=>
        $stable({o_octal_en, o_double_rate, o_single_transfer_rate}))
        else $error("mode moved");
endmodule : rate_mode_props
bind octal_rate_mode_descriptors rate_mode_props rate_mode_props_inst (.*);

// >>> host_model.sv
`timescale 1ns/1ps
module host_model (
    input  wire logic        i_clk,
    output logic             o_cmd_valid, o_txn_start, o_pt_rd,
    output logic [7:0]       o_cmd_code, o_cmd_wdata,
    output logic [8:0]       o_pt_addr,
    output logic [23:0]      o_cmd_addr
);
    // Idle lines at time zero
    initial {o_cmd_valid, o_txn_start, o_pt_rd, o_cmd_code, o_cmd_wdata, o_pt_addr, o_cmd_addr} = '0;
    // One strobe held for one edge; released strobes drop to zero, address lines show the inverse
    task automatic drive(input logic [2:0] s, input logic [7:0] c, input logic [23:0] a,
        input logic [7:0] d);
        @(posedge i_clk);
        {o_cmd_valid, o_txn_start, o_pt_rd, o_cmd_code, o_cmd_addr, o_pt_addr, o_cmd_wdata}
            <= {s, c, a, a[8:0], d};
        @(posedge i_clk);
        {o_cmd_valid, o_txn_start, o_pt_rd, o_cmd_addr, o_pt_addr} <= {3'b000, ~a, ~a[8:0]};
    endtask : drive
endmodule : host_model

// >>> octal_rate_mode_descriptors_tb.sv
`timescale 1ns/1ps
module octal_rate_mode_descriptors_tb;
    localparam logic [23:0] VOL = 24'h800006, NV = 24'h000006, BAD = 24'h800007;
    logic        i_clk, i_arst_n, i_cmd_valid, i_txn_start, i_pt_rd, o_rd_valid, o_pt_valid;
    logic        o_octal_en, o_double_rate, o_single_transfer_rate;
    logic [7:0]  i_cmd_code, i_cmd_wdata, o_rd_data, o_pt_data;
    logic [8:0]  i_pt_addr;
    logic [23:0] i_cmd_addr;
    int          fails, n_checks;
    host_model host_model_inst (.i_clk, .o_cmd_valid(i_cmd_valid), .o_txn_start(i_txn_start),
        .o_pt_rd(i_pt_rd), .o_cmd_code(i_cmd_code), .o_cmd_wdata(i_cmd_wdata),
        .o_pt_addr(i_pt_addr), .o_cmd_addr(i_cmd_addr));
    octal_rate_mode_descriptors octal_rate_mode_descriptors_inst (.*);
    // Compare one byte and count
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Listed table bytes, one request every two cycles, then an unlisted one
    task automatic t_table;
        logic [8:0] a [5] = '{9'h1BB, 9'h1BF, 9'h1C3, 9'h1C7, 9'h1C0};
        logic [7:0] d [5] = '{8'hD1, 8'hD1, 8'h91, 8'h91, 8'h00};
        for (int k = 0; k < 5; k++) begin
            host_model_inst.drive(3'b001, 8'h00, {15'h0000, a[k]}, 8'h00);
            #1 chk("table", d[k], o_pt_valid ? o_pt_data : 8'hXX);
        end
    endtask : t_table
    // Foreign code, unmapped address, copies kept apart
    task automatic t_regs;
        logic [7:0]  c [9] = '{8'h66, 8'h71, 8'h71, 8'h65, 8'h65, 8'h71, 8'h65, 8'h65, 8'h65};
        logic [23:0] a [9] = '{VOL, BAD, VOL, VOL, NV, NV, NV, VOL, BAD};
        logic [7:0]  d [9] = '{8'hFF, 8'hFF, 8'h5A, 8'h5A, 8'h02, 8'hA5, 8'hA5, 8'h5A, 8'h00};
        for (int k = 0; k < 9; k++) begin
            host_model_inst.drive(3'b100, c[k], a[k], d[k]);
            if (c[k] == 8'h65) #1 chk("reg", d[k], o_rd_valid ? o_rd_data : 8'hXX);
        end
    endtask : t_regs
    // Rate written, unchanged until a transaction starts
    task automatic t_mode;
        logic [7:0] w [4] = '{8'h03, 8'h01, 8'h00, 8'h02};
        logic [7:0] m = 8'h00;
        for (int k = 0; k < 4; k++) begin
            host_model_inst.drive(3'b100, 8'h71, VOL, w[k]);
            #1 chk("held", m, {5'h00, o_octal_en, o_double_rate, o_single_transfer_rate});
            host_model_inst.drive(3'b010, 8'h00, 24'h000000, 8'h00);
            m = {5'h00, w[k][0], &w[k][1:0], w[k][1:0] == 2'b01};
            @(posedge i_clk);
            #1 chk("mode", m, {5'h00, o_octal_en, o_double_rate, o_single_transfer_rate});
        end
    endtask : t_mode
    // Verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop
    // Clock, 20 ns period
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    // Reset two cycles, then the scenarios
    initial begin
        i_arst_n = 1'b0;
        repeat (2) @(posedge i_clk);
        i_arst_n <= 1'b1;
        t_table();
        t_regs();
        t_mode();
        report_and_stop();
    end
    // Watchdog, far beyond the 50 or so cycles needed
    initial begin
        #20us;
        fails++;
        report_and_stop();
    end
endmodule : octal_rate_mode_descriptors_tb
